// ---- verilog/cpu_status_flag_register.sv ----
// Purpose: CPU status flag register with AXI4-Lite access and flag events
// Assumes: Datapath inputs come from logic on aclk
// Notes:   Reads of event status clear it; set wins over clear
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "cpu_status_flags_regs.svh"
module cpu_status_flag_register (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`ADDR_BITS-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ADDR_BITS-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic acc_update,
   input wire logic acc_a_overflow_in,
   input wire logic acc_b_overflow_in,
   input wire logic acc_a_saturate_in,
   input wire logic acc_b_saturate_in,
   input wire logic alu_update,
   input wire logic [15:0] alu_opnd_a,
   input wire logic [15:0] alu_opnd_b,
   input wire logic alu_carry_in,
   input wire logic alu_byte_mode,
   input wire logic alu_negative,
   input wire logic alu_overflow,
   input wire logic alu_zero,
   input wire logic alu_carry,
   input wire logic loop_active,
   input wire logic repeat_active,
   input wire logic nesting_disable,
   input wire logic priority_msb,
   output logic [15:0] cpu_status_flags,
   output logic [3:0] cpu_priority_level,
   output logic irq
);

   // ==========================================================
   // Storage
   cpu_status_pkg::flag_word_t flags_reg;
   logic [3:0] acc_reg;
   logic [4:0] arith_reg;
   logic [2:0] prio_reg;
   cpu_status_pkg::evt_word_t evt_reg;
   cpu_status_pkg::evt_word_t mask_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [`ADDR_BITS-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic wr_go;
   logic rd_go;
   logic flags_wr;
   logic lo_wr;
   logic hi_wr;
   logic evt_rd_clr;
   cpu_status_pkg::evt_word_t evt_set;
   half_carry_if hc_bus ();

   // Address is one of the three mapped words
   function automatic logic addr_mapped(input logic [`ADDR_BITS-1:0] a);
      return (a == `ADDR_FLAGS) || (a == `ADDR_EVT_STATUS) || (a == `ADDR_EVT_MASK);
   endfunction

   // ==========================================================
   // Half carry unit
   assign hc_bus.opnd_a = alu_opnd_a;
   assign hc_bus.opnd_b = alu_opnd_b;
   assign hc_bus.carry_in = alu_carry_in;
   assign hc_bus.byte_mode = alu_byte_mode;

   half_carry_calc u_half_carry (
      .hc(hc_bus)
   );

   // ==========================================================
   // AXI write channel: address and data taken in either order
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
   assign flags_wr = wr_go && (awaddr_reg == `ADDR_FLAGS);
   assign lo_wr = flags_wr && wstrb_reg[0];
   assign hi_wr = flags_wr && wstrb_reg[1];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_mapped(awaddr_reg) ? cpu_status_pkg::RESP_OKAY
                                                 : cpu_status_pkg::RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // ==========================================================
   // AXI read channel: answer one cycle after the address is taken
   assign s_axi_arready = !rvalid_reg;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign evt_rd_clr = rd_go && (s_axi_araddr == `ADDR_EVT_STATUS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= 2'h0;
      end else if (rd_go) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= addr_mapped(s_axi_araddr) ? cpu_status_pkg::RESP_OKAY
                                                : cpu_status_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            `ADDR_FLAGS: rdata_reg <= {16'h0000, flags_reg};
            `ADDR_EVT_STATUS: rdata_reg <= {28'h0000000, evt_reg};
            `ADDR_EVT_MASK: rdata_reg <= {28'h0000000, mask_reg};
            default: rdata_reg <= 32'h00000000;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ==========================================================
   // Accumulator flags: overflow follows each update, saturation is sticky
   // Bits 3 down to 0: A overflow, B overflow, A saturated, B saturated
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_reg <= 4'h0;
      end else begin
         if (acc_update) begin
            acc_reg[3] <= acc_a_overflow_in;
            acc_reg[2] <= acc_b_overflow_in;
         end
         // Write of zero clears a flag or both via the combined bit; set wins
         if (hi_wr && (!wdata_reg[`BIT_ACC_A_SAT] || !wdata_reg[`BIT_EITHER_SAT])) begin // RQ6 RQ7
            acc_reg[1] <= 1'b0;
         end
         if (hi_wr && (!wdata_reg[`BIT_ACC_B_SAT] || !wdata_reg[`BIT_EITHER_SAT])) begin // RQ6 RQ7
            acc_reg[0] <= 1'b0;
         end
         if (acc_update && acc_a_saturate_in) begin
            acc_reg[1] <= 1'b1;
         end
         if (acc_update && acc_b_saturate_in) begin
            acc_reg[0] <= 1'b1; // RQ1
         end
      end
   end

   // Flag word: stored fields, combined flags and mirrored loop state
   assign flags_reg = {acc_reg,
                       acc_reg[3] | acc_reg[2], // RQ2
                       acc_reg[1] | acc_reg[0], // RQ3
                       loop_active, arith_reg[4], prio_reg, repeat_active, arith_reg[3:0]};

   // ==========================================================
   // Arithmetic flags: ALU update wins over a software write
   // Bit 4 half carry, bits 3 down to 0 negative, overflow, zero, carry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arith_reg <= 5'h00;
      end else if (alu_update) begin
         arith_reg[4] <= hc_bus.half_carry; // RQ4
         arith_reg[3:0] <= {alu_negative, alu_overflow, alu_zero, alu_carry};
      end else begin
         if (hi_wr) begin
            arith_reg[4] <= wdata_reg[`BIT_HALF_CARRY];
         end
         if (lo_wr) begin
            arith_reg[3:0] <= wdata_reg[`BIT_NEGATIVE:`BIT_CARRY];
         end
      end
   end

   // ==========================================================
   // Priority field: locked while nesting is disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio_reg <= 3'h0;
      end else if (lo_wr && !nesting_disable) begin // RQ8
         prio_reg <= wdata_reg[`BIT_PRIO_HI:`BIT_PRIO_LO];
      end
   end

   assign cpu_priority_level = {priority_msb, prio_reg}; // RQ5
   assign cpu_status_flags = flags_reg;

   // ==========================================================
   // Event status, mask and interrupt
   assign evt_set[`EVT_ACC_A_SAT] = acc_update && acc_a_saturate_in;
   assign evt_set[`EVT_ACC_B_SAT] = acc_update && acc_b_saturate_in;
   assign evt_set[`EVT_ACC_A_OVF] = acc_update && acc_a_overflow_in;
   assign evt_set[`EVT_ACC_B_OVF] = acc_update && acc_b_overflow_in;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_reg <= `EVT_RESET;
      end else begin
         evt_reg <= (evt_rd_clr ? 4'h0 : evt_reg) | evt_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_reg <= `EVT_RESET;
      end else if (wr_go && (awaddr_reg == `ADDR_EVT_MASK) && wstrb_reg[0]) begin
         mask_reg <= wdata_reg[`EVT_COUNT-1:0];
      end
   end

   assign irq = |(evt_reg & mask_reg);

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sticky_b_set_a: assert property (acc_update && acc_b_saturate_in |=> cpu_status_flags[12]) // RQ1
      else $error("B saturation did not set sticky flag");
   sticky_b_keep_a: assert property (cpu_status_flags[12] && !hi_wr |=> cpu_status_flags[12]) // RQ1
      else $error("B saturation flag dropped without clear");
   either_ovf_a: assert property (acc_update |=> cpu_status_flags[11] ==
                                  $past(acc_a_overflow_in || acc_b_overflow_in)) // RQ2
      else $error("Combined overflow wrong after update");
   either_sat_a: assert property (acc_update && acc_a_saturate_in |=> cpu_status_flags[10]) // RQ3
      else $error("Combined saturation not set");
   half_carry_byte_a: assert property (alu_update && alu_byte_mode |=> // RQ4
      cpu_status_flags[8] ==
      $past(({1'b0, alu_opnd_a[3:0]} + {1'b0, alu_opnd_b[3:0]} + {4'h0, alu_carry_in}) > 5'h0F))
      else $error("Byte half carry wrong");
   prio_concat_a: assert property ( // RQ5
      cpu_priority_level == {priority_msb, cpu_status_flags[7:5]})
      else $error("Priority level concatenation wrong");
   no_sw_set_a: assert property ( // RQ6
      hi_wr && !flags_reg[13] && !acc_update |=> !cpu_status_flags[13])
      else $error("Software set a saturation flag");
   sat_clear_both_a: assert property (hi_wr && !wdata_reg[10] && !acc_update // RQ7
                                      |=> !cpu_status_flags[13] && !cpu_status_flags[12])
      else $error("Combined clear left a flag set");
   prio_locked_a: assert property (nesting_disable |=> $stable(cpu_status_flags[7:5])) // RQ8
      else $error("Priority field changed while locked");
   irq_level_a: assert property ((evt_set & mask_reg) != 4'h0 && !wr_go |=> irq)
      else $error("Masked-in event raised no interrupt");

   sat_seen_c: cover property (acc_update && acc_b_saturate_in ##1 cpu_status_flags[12]);
   sat_cleared_c: cover property (cpu_status_flags[10] ##1 !cpu_status_flags[10]);
   prio_write_c: cover property (lo_wr && !nesting_disable);
   irq_c: cover property (irq ##[1:20] !irq);

endmodule

// ---- shared/cpu_status_flags_regs.svh ----
// Purpose: Offsets, field positions, reset values for the CPU status flag block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   Definitions only
//
// Behaviour
// [RQ1] Accumulator B saturation flag sets on saturation and stays until software clears it.
// [RQ2] Combined overflow flag reads as accumulator A overflow OR accumulator B overflow.
// [RQ3] Combined saturation flag reads as OR of both sticky saturation flags.
// [RQ4] Half carry is carry out of bit 3 (byte) or bit 7 (word).
// [RQ5] Three priority bits are low bits; separate high bit completes current level.
// [RQ6] Software may read and clear saturation flags, but writing one never sets them.
// [RQ7] Clearing the combined saturation flag clears both accumulator saturation flags.
// [RQ8] Priority field ignores software writes while nesting disable is set.
`ifndef CPU_STATUS_FLAGS_REGS_SVH
`define CPU_STATUS_FLAGS_REGS_SVH

// ==========================================================
// Register byte addresses
`define ADDR_FLAGS 8'h00
`define ADDR_EVT_STATUS 8'h04
`define ADDR_EVT_MASK 8'h08
`define ADDR_BITS 8

// ==========================================================
// Flag word field positions
`define BIT_ACC_A_OVF 15
`define BIT_ACC_B_OVF 14
`define BIT_ACC_A_SAT 13
`define BIT_ACC_B_SAT 12
`define BIT_EITHER_OVF 11
`define BIT_EITHER_SAT 10
`define BIT_LOOP_ACTIVE 9
`define BIT_HALF_CARRY 8
`define BIT_PRIO_HI 7
`define BIT_PRIO_LO 5
`define BIT_REPEAT_ACTIVE 4
`define BIT_NEGATIVE 3
`define BIT_ARITH_OVF 2
`define BIT_ZERO 1
`define BIT_CARRY 0

// ==========================================================
// Event status / mask bit positions
`define EVT_ACC_A_SAT 0
`define EVT_ACC_B_SAT 1
`define EVT_ACC_A_OVF 2
`define EVT_ACC_B_OVF 3
`define EVT_COUNT 4

// ==========================================================
// Reset values
`define FLAGS_RESET 16'h0000
`define EVT_RESET 4'h0

`endif

// ---- shared/cpu_status_pkg.sv ----
// Purpose: Types shared by the CPU status flag block
// Assumes: Nothing beyond AXI4-Lite response coding
// Notes:   Constants live in the register header
package cpu_status_pkg;

   // ==========================================================
   // AXI response codes
   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_e;

   // ==========================================================
   // Word types
   typedef logic [15:0] flag_word_t;
   typedef logic [3:0] evt_word_t;

endpackage

// ---- shared/half_carry_if.sv ----
// Purpose: Carries ALU operands to the half carry unit and its answer back
// Assumes: Same clock domain on both ends, purely combinational
// Notes:   alu end drives operands, calc end answers
`timescale 1ns/1ps
interface half_carry_if;
   logic [15:0] opnd_a;
   logic [15:0] opnd_b;
   logic carry_in;
   logic byte_mode;
   logic half_carry;

   modport alu (output opnd_a, output opnd_b, output carry_in, output byte_mode,
                input half_carry);
   modport calc (input opnd_a, input opnd_b, input carry_in, input byte_mode,
                 output half_carry);
endinterface

// ---- verilog/half_carry_calc.sv ----
// Purpose: Half carry out of the low nibble or low byte of an addition
// Assumes: Operands stable during the ALU update cycle
// Notes:   Combinational only
`timescale 1ns/1ps
module half_carry_calc (
   half_carry_if.calc hc
);

   // Carry out of a low field of given width
   function automatic logic field_carry(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin, input logic nibble);
      logic [8:0] sum;
      sum = 9'h000;
      if (nibble) begin
         sum = {5'h00, a[3:0]} + {5'h00, b[3:0]} + {8'h00, cin};
         return sum[4];
      end
      sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      return sum[8];
   endfunction

   // Byte data carries from bit 3, word data from bit 7
   assign hc.half_carry = field_carry(hc.opnd_a[7:0], hc.opnd_b[7:0],
                                      hc.carry_in, hc.byte_mode); // RQ4

endmodule

// ---- verif/tb_cpu_status_flag_register.sv ----
// Purpose: Self-checking bench for the CPU status flag register
// Assumes: AXI4-Lite timing and register map as in the design hand-over
// Notes:   Datapath update table first, register and event tests after
`timescale 1ns/1ps
`include "cpu_status_flags_regs.svh"
module tb_cpu_status_flag_register;
   // ==========================================================
   // Signals and stimulus table
   typedef struct {
      logic acc;
      logic [3:0] av;
      logic alu;
      logic bm;
      logic [15:0] a;
      logic [15:0] b;
      logic cin;
      logic [3:0] nz;
      cpu_status_pkg::flag_word_t ef;
   } row_s;
   row_s rows [11];
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, acc_in, alu_nz, prio;
   logic [1:0] bresp, rresp;
   logic acc_update, alu_update, alu_carry_in, alu_byte_mode;
   logic [15:0] alu_opnd_a, alu_opnd_b;
   logic loop_active, repeat_active, nesting_disable, priority_msb;
   cpu_status_pkg::flag_word_t flags;
   int err_total, n_tests, i;

   cpu_status_flag_register i_cpu_status_flag_register (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .acc_update(acc_update), .acc_a_overflow_in(acc_in[3]), .acc_b_overflow_in(acc_in[2]),
      .acc_a_saturate_in(acc_in[1]), .acc_b_saturate_in(acc_in[0]),
      .alu_update(alu_update), .alu_opnd_a(alu_opnd_a), .alu_opnd_b(alu_opnd_b),
      .alu_carry_in(alu_carry_in), .alu_byte_mode(alu_byte_mode),
      .alu_negative(alu_nz[3]), .alu_overflow(alu_nz[2]), .alu_zero(alu_nz[1]),
      .alu_carry(alu_nz[0]), .loop_active(loop_active), .repeat_active(repeat_active),
      .nesting_disable(nesting_disable), .priority_msb(priority_msb),
      .cpu_status_flags(flags), .cpu_priority_level(prio), .irq(irq)
   );

   // ==========================================================
   // Clock, checking and closing
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // Bus and datapath drivers
   // One write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (k == 20) err_total++;
      if (k == 20) tally_and_finish();
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
      @(negedge aclk);
   endtask

   // One read: rready held until the answer is sampled
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (k == 20) err_total++;
      if (k == 20) tally_and_finish();
      rready <= 1'b0;
      chk(rdata, ed);
      chk(32'(rresp), 32'(er));
      @(negedge aclk);
   endtask

   // One-cycle datapath update pulse, result looked at the following negedge
   task automatic upd(input row_s r);
      @(posedge aclk);
      acc_update <= r.acc;
      acc_in <= r.av;
      alu_update <= r.alu;
      alu_byte_mode <= r.bm;
      alu_opnd_a <= r.a;
      alu_opnd_b <= r.b;
      alu_carry_in <= r.cin;
      alu_nz <= r.nz;
      @(posedge aclk);
      acc_update <= 1'b0;
      alu_update <= 1'b0;
      @(negedge aclk);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, acc_update, alu_update} = 8'h00;
      {awaddr, araddr, wdata, acc_in, alu_nz, alu_carry_in, alu_byte_mode} = 58'h0;
      {alu_opnd_a, alu_opnd_b, loop_active, repeat_active, nesting_disable} = 35'h0;
      priority_msb = 1'b0;
      wstrb = 4'h3;
      err_total = 0;
      n_tests = 0;
      // acc: {A ovf, B ovf, A sat, B sat}; alu: byte mode, operands, carry in, N/OV/Z/C
      rows = '{'{1'b1, 4'h4, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 16'h4800},
               '{1'b1, 4'h8, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 16'h8800},
               '{1'b1, 4'h1, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 16'h1400},
               '{1'b1, 4'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 16'h1400},
               '{1'b1, 4'h2, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 16'h3400},
               '{1'b0, 4'h0, 1'b1, 1'b1, 16'h0008, 16'h0008, 1'b0, 4'h0, 16'h3500},
               '{1'b0, 4'h0, 1'b1, 1'b1, 16'h0007, 16'h0008, 1'b0, 4'h0, 16'h3400},
               '{1'b0, 4'h0, 1'b1, 1'b1, 16'h0007, 16'h0008, 1'b1, 4'h0, 16'h3500},
               '{1'b0, 4'h0, 1'b1, 1'b0, 16'h0080, 16'h0080, 1'b0, 4'h0, 16'h3500},
               '{1'b0, 4'h0, 1'b1, 1'b0, 16'h0008, 16'h0008, 1'b0, 4'h0, 16'h3400},
               '{1'b0, 4'h0, 1'b1, 1'b0, 16'h007F, 16'h0000, 1'b1, 4'hF, 16'h340F}};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(32'(flags), 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      axi_rd(`ADDR_EVT_MASK, 32'h0000_0000, 2'h0);
      // Ordinary cases: datapath updates and the flags they must leave
      for (i = 0; i < 11; i++) begin
         upd(rows[i]);
         chk(32'(flags), 32'(rows[i].ef));
      end
      // Events: masked, unmasked, read-to-clear, re-raised
      chk(32'(irq), 32'h0000_0000);
      axi_wr(`ADDR_EVT_MASK, 32'h0000_0002, 2'h0);
      chk(32'(irq), 32'h0000_0001);
      axi_rd(`ADDR_EVT_STATUS, 32'h0000_000F, 2'h0);
      axi_rd(`ADDR_EVT_STATUS, 32'h0000_0000, 2'h0);
      chk(32'(irq), 32'h0000_0000);
      upd(rows[2]);
      chk(32'(irq), 32'h0000_0001);
      axi_wr(`ADDR_EVT_MASK, 32'h0000_0000, 2'h0);
      chk(32'(irq), 32'h0000_0000);
      // Clear B saturation only, A keeps the combined flag up
      axi_wr(`ADDR_FLAGS, 32'h0000_EFFF, 2'h0);
      chk(32'(flags), 32'h0000_25EF);
      @(posedge aclk);
      priority_msb <= 1'b1;
      @(negedge aclk);
      chk(32'(prio), 32'h0000_000F);
      // Combined clear drops both; ones written are ignored; priority locked
      @(posedge aclk);
      nesting_disable <= 1'b1;
      axi_wr(`ADDR_FLAGS, 32'h0000_FB1F, 2'h0);
      chk(32'(flags), 32'h0000_01EF);
      chk(32'(prio), 32'h0000_000F);
      @(posedge aclk);
      nesting_disable <= 1'b0;
      loop_active <= 1'b1;
      repeat_active <= 1'b1;
      axi_wr(`ADDR_FLAGS, 32'h0000_0000, 2'h0);
      axi_rd(`ADDR_FLAGS, 32'h0000_0210, 2'h0);
      chk(32'(prio), 32'h0000_0008);
      // Unmapped place answers with an error and zero data
      axi_wr(8'h0C, 32'h0000_FFFF, 2'h2);
      axi_rd(8'h0C, 32'h0000_0000, 2'h2);
      // Reset in mid-run wipes sticky state
      upd(rows[2]);
      @(posedge aclk);
      aresetn <= 1'b0;
      loop_active <= 1'b0;
      repeat_active <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(32'(flags), 32'h0000_0000);
      axi_rd(`ADDR_EVT_STATUS, 32'h0000_0000, 2'h0);
      tally_and_finish();
   end
endmodule
